// File: ezram_dpram.sv
// two port byte ram shared by the bus side and the cpu side
module ezram_dpram #(
    parameter int DW = 8,
    parameter int AW = 5,
    parameter int DEPTH = 32
) (
    // clock
    input wire logic clk,
    // bus port
    input wire logic a_we,
    input wire logic [AW-1:0] a_addr,
    input wire logic [DW-1:0] a_wdata,
    output logic [DW-1:0] a_rdata,
    // cpu port
    input wire logic b_we,
    input wire logic [AW-1:0] b_addr,
    input wire logic [DW-1:0] b_wdata,
    output logic [DW-1:0] b_rdata
);

    // contents are not initialised; unwritten cells read undefined
    logic [DW-1:0] mem [DEPTH];

    // ****************************************
    // writes: both ports in one cycle, bus port wins a same address clash
    // ****************************************
    always_ff @(posedge clk) begin
        if (b_we && !(a_we && (a_addr == b_addr))) begin
            mem[b_addr] <= b_wdata;
        end
        if (a_we) begin
            mem[a_addr] <= a_wdata;
        end
    end

    // reads are combinational so the caller can register them once
    assign a_rdata = mem[a_addr];
    assign b_rdata = mem[b_addr];

endmodule

// File: ezram_master_model.sv
// model of the external bus master, seen as serial engine events
module ezram_master_model (
    // clock
    input wire logic clk,
    // events towards the block
    output logic start,
    output logic stop,
    output logic match,
    output logic rd,
    output logic done,
    output ezram_pkg::byte_t wdata,
    // data from the block
    input wire ezram_pkg::byte_t rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    import ezram_pkg::*;
    byte_t got[$];
    initial {start, stop, match, rd, done, wdata} = '0;
    // one event per cycle; released data toggles so it never looks held
    task automatic ev(input logic [4:0] e, input byte_t d);
        {start, stop, match, rd, done} = e;
        wdata = e[0] ? d : ~wdata;
        @(posedge clk);
        #1;
    endtask
    // master write: first byte sets the base, then data bytes
    task automatic wr(input byte_t base, input byte_t q[$]);
        ev(5'b10000, 8'h00);
        ev(5'b00100, 8'h00);
        ev(5'b00001, base);
        foreach (q[i]) ev(5'b00001, q[i]);
        ev(5'b01000, 8'h00);
        ev(5'b00000, 8'h00);
    endtask
    // master read of n bytes from the base onwards
    task automatic rd_n(input int n);
        got.delete();
        ev(5'b10000, 8'h00);
        ev(5'b00110, 8'h00);
        repeat (n) begin
            got.push_back(rdata);
            ev(5'b00011, 8'h00);
            ev(5'b00010, 8'h00);
        end
        ev(5'b01000, 8'h00);
        ev(5'b00000, 8'h00);
    endtask
endmodule

// File: ezram_params.svh
// constants for the shared ram pointer block
`ifndef EZRAM_PARAMS_SVH
`define EZRAM_PARAMS_SVH

// ****************************************
// register offsets
// ****************************************
`define OFS_BUS_CURRENT_POINTER 8'hcc
`define OFS_HOST_BASE_POINTER 8'hcd
`define OFS_HOST_CURRENT_POINTER 8'hce
`define OFS_HOST_BUFFER_PORT 8'hcf

// ****************************************
// field layout and reset values
// ****************************************
`define PTR_W 5
`define PTR_MSB 4
`define BUF_DEPTH 32
`define DATA_W 8
`define PTR_RESET 5'h00
`define DATA_RESET 8'h00
`define PTR_PAD_W 3

`endif

// File: ezram_pkg.sv
// types shared by the shared ram pointer block
package ezram_pkg;

    // ****************************************
    // bus side transaction phase
    // ****************************************
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_WAIT_BASE = 2'b01,
        BUS_WRITE_DATA = 2'b10,
        BUS_READ_DATA = 2'b11
    } bus_phase_t;

    typedef logic [4:0] ptr_t;
    typedef logic [7:0] byte_t;

endpackage

// File: ezram_ptr_pair.sv
// base pointer with its auto incrementing current pointer
module ezram_ptr_pair #(
    parameter int PW = 5
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // control
    input wire logic base_load,
    input wire logic [PW-1:0] base_val,
    input wire logic restart,
    input wire logic incr,
    // pointers
    output logic [PW-1:0] base_q,
    output logic [PW-1:0] cur_q
);

    // ****************************************
    // base pointer, changed only by a load
    // ****************************************
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            base_q <= '0;
        end else if (base_load) begin
            base_q <= base_val;
        end
    end

    // load beats restart, restart beats increment; natural wrap at the top
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            cur_q <= '0;
        end else if (base_load) begin
            cur_q <= base_val;
        end else if (restart) begin
            cur_q <= base_q;
        end else if (incr) begin
            cur_q <= cur_q + {{(PW-1){1'b0}}, 1'b1};
        end
    end

endmodule

// File: ezram_top.sv
// pointer and access logic of the 32 byte shared ram in ram emulation mode
//
// What this block does
// - loading the bus base pointer loads the bus current pointer with it.
// - bus current pointer increments after each completed data byte.
// - every bus data byte uses the location of the bus current pointer.
// - each start condition reloads bus current pointer from bus base pointer.
// - bus current pointer is cpu read only and resets to zero.
// - cpu base pointer is cpu read write, changed only by writes, resets zero.
// - writing cpu base pointer copies the value into cpu current pointer.
// - first data port access after a base write uses the new base.
// - cpu current pointer read only, resets zero, increments per port access.
// - reading the data port returns the byte at cpu current pointer.
// - writing the data port stores the byte at cpu current pointer.
// - unwritten ram locations read undefined; ram is not initialised.
// - first written byte after the address becomes the bus base pointer.
// - bus base pointer changes only in a write; reads reuse it.
// - the ram looks like 32 bytes to the master and never stalls.
`include "ezram_params.svh"

module ezram_top (
    // clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // mode
    input wire logic RAM_MODE,
    // cpu register port
    input wire logic [7:0] CPU_ADDR,
    input wire logic CPU_WR,
    input wire logic CPU_RD,
    input wire ezram_pkg::byte_t CPU_WDATA,
    output ezram_pkg::byte_t CPU_RDATA,
    // bus side events from the serial engine
    input wire logic BUS_START,
    input wire logic BUS_STOP,
    input wire logic BUS_ADDR_MATCH,
    input wire logic BUS_READ,
    input wire logic BUS_BYTE_DONE,
    input wire ezram_pkg::byte_t BUS_WDATA,
    // bus side results
    output ezram_pkg::byte_t BUS_RDATA,
    output logic BUS_BUSY,
    output logic BUS_DIR_READ
);
    import ezram_pkg::*;

    // ****************************************
    // internal signals
    // ****************************************
    bus_phase_t phase_q;
    bus_phase_t phase_d;
    ptr_t bus_base;
    ptr_t bus_cur;
    ptr_t host_base;
    ptr_t host_cur;
    byte_t bus_ram_rdata;
    byte_t host_ram_rdata;
    byte_t cpu_rdata_q;
    byte_t cpu_rdata_d;
    byte_t bus_rdata_q;
    logic bus_busy_q;
    logic bus_dir_q;
    logic bus_base_load;
    logic bus_restart;
    logic bus_incr;
    logic bus_ram_we;
    logic host_base_load;
    logic host_port_hit;
    logic host_incr;
    logic host_ram_we;

    // decodes a register offset against the cpu address
    function automatic logic addr_is(input logic [7:0] a, input logic [7:0] ofs);
        addr_is = (a == ofs);
    endfunction

    // ****************************************
    // bus side phase tracking
    // ****************************************
    // start wins over any byte completion in the same cycle
    always_comb begin
        phase_d = phase_q;
        if (!RAM_MODE) begin
            phase_d = BUS_IDLE;
        end else if (BUS_START || BUS_STOP) begin
            phase_d = BUS_IDLE;
        end else begin
            case (phase_q)
                BUS_IDLE: begin
                    if (BUS_ADDR_MATCH) begin
                        phase_d = BUS_READ ? BUS_READ_DATA : BUS_WAIT_BASE;
                    end
                end
                BUS_WAIT_BASE: begin
                    if (BUS_BYTE_DONE) begin
                        phase_d = BUS_WRITE_DATA;
                    end
                end
                BUS_WRITE_DATA: phase_d = BUS_WRITE_DATA;
                BUS_READ_DATA: phase_d = BUS_READ_DATA;
                default: phase_d = BUS_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            phase_q <= BUS_IDLE;
        end else begin
            phase_q <= phase_d;
        end
    end

    // ****************************************
    // bus side pointer control
    // ****************************************
    // the first byte of a write is the base, never ram data
    assign bus_base_load = RAM_MODE && !BUS_START && !BUS_STOP && BUS_BYTE_DONE
                           && (phase_q == BUS_WAIT_BASE);
    // every start, including a repeated one, rewinds to the base
    assign bus_restart = RAM_MODE && BUS_START;
    // data bytes of either direction step the pointer
    assign bus_incr = RAM_MODE && !BUS_START && !BUS_STOP && BUS_BYTE_DONE
                      && ((phase_q == BUS_WRITE_DATA) || (phase_q == BUS_READ_DATA));
    // written data lands at the current pointer, no wait states
    assign bus_ram_we = bus_incr && (phase_q == BUS_WRITE_DATA);

    ezram_ptr_pair #(
        .PW(`PTR_W)
    ) u_bus_ptr (
        .clk(CLK),
        .rst_n(RSTN),
        .base_load(bus_base_load),
        .base_val(BUS_WDATA[`PTR_MSB:0]),
        .restart(bus_restart),
        .incr(bus_incr),
        .base_q(bus_base),
        .cur_q(bus_cur)
    );

    // ****************************************
    // cpu side pointer control
    // ****************************************
    // only a cpu write moves the cpu base, and it moves the current too
    assign host_base_load = CPU_WR && addr_is(CPU_ADDR, `OFS_HOST_BASE_POINTER);
    assign host_port_hit = addr_is(CPU_ADDR, `OFS_HOST_BUFFER_PORT);
    // one step per data port access; read and write in one cycle step once
    assign host_incr = host_port_hit && (CPU_WR || CPU_RD);
    assign host_ram_we = host_port_hit && CPU_WR;

    ezram_ptr_pair #(
        .PW(`PTR_W)
    ) u_host_ptr (
        .clk(CLK),
        .rst_n(RSTN),
        .base_load(host_base_load),
        .base_val(CPU_WDATA[`PTR_MSB:0]),
        .restart(1'b0),
        .incr(host_incr),
        .base_q(host_base),
        .cur_q(host_cur)
    );

    // ****************************************
    // shared ram
    // ****************************************
    // separate ports let both sides finish in the same cycle
    ezram_dpram #(
        .DW(`DATA_W),
        .AW(`PTR_W),
        .DEPTH(`BUF_DEPTH)
    ) u_ram (
        .clk(CLK),
        .a_we(bus_ram_we),
        .a_addr(bus_cur),
        .a_wdata(BUS_WDATA),
        .a_rdata(bus_ram_rdata),
        .b_we(host_ram_we),
        .b_addr(host_cur),
        .b_wdata(CPU_WDATA),
        .b_rdata(host_ram_rdata)
    );

    // ****************************************
    // cpu read data
    // ****************************************
    // unmapped offsets read back zero; writes to read only pointers are ignored
    always_comb begin
        cpu_rdata_d = cpu_rdata_q;
        if (CPU_RD) begin
            if (addr_is(CPU_ADDR, `OFS_BUS_CURRENT_POINTER)) begin
                cpu_rdata_d = {{`PTR_PAD_W{1'b0}}, bus_cur};
            end else if (addr_is(CPU_ADDR, `OFS_HOST_BASE_POINTER)) begin
                cpu_rdata_d = {{`PTR_PAD_W{1'b0}}, host_base};
            end else if (addr_is(CPU_ADDR, `OFS_HOST_CURRENT_POINTER)) begin
                cpu_rdata_d = {{`PTR_PAD_W{1'b0}}, host_cur};
            end else if (host_port_hit) begin
                cpu_rdata_d = host_ram_rdata;
            end else begin
                cpu_rdata_d = `DATA_RESET;
            end
        end
    end

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            cpu_rdata_q <= `DATA_RESET;
        end else begin
            cpu_rdata_q <= cpu_rdata_d;
        end
    end

    // ****************************************
    // bus read data and status
    // ****************************************
    // byte at the bus current pointer, refreshed every cycle
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            bus_rdata_q <= `DATA_RESET;
        end else begin
            bus_rdata_q <= bus_ram_rdata;
        end
    end

    // busy from address match to stop, with the transfer direction
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            bus_busy_q <= 1'b0;
            bus_dir_q <= 1'b0;
        end else if (!RAM_MODE || BUS_STOP) begin
            bus_busy_q <= 1'b0;
            bus_dir_q <= 1'b0;
        end else if (BUS_ADDR_MATCH && !BUS_START) begin
            bus_busy_q <= 1'b1;
            bus_dir_q <= BUS_READ;
        end
    end

    assign CPU_RDATA = cpu_rdata_q;
    assign BUS_RDATA = bus_rdata_q;
    assign BUS_BUSY = bus_busy_q;
    assign BUS_DIR_READ = bus_dir_q;

endmodule

// File: ezram_top_chk.sv
// port checker of the shared ram pointer block
module ezram_top_chk (
    // clock and reset
    input wire logic CLK,
    input wire logic RSTN,
    // cpu side
    input wire logic [7:0] CPU_ADDR,
    input wire logic CPU_WR,
    input wire logic CPU_RD,
    input wire ezram_pkg::byte_t CPU_WDATA,
    input wire ezram_pkg::byte_t CPU_RDATA,
    // bus side
    input wire logic RAM_MODE,
    input wire logic BUS_ADDR_MATCH,
    input wire logic BUS_READ,
    input wire logic BUS_STOP,
    input wire logic BUS_BUSY,
    input wire logic BUS_DIR_READ
);
    timeunit 1ns;
    timeprecision 100ps;
    import ezram_pkg::*;
    default clocking @(posedge CLK); endclocking
    default disable iff (!RSTN);
    // pointer register reads and matches seen from idle
    wire ptr_rd = CPU_RD && CPU_ADDR inside {8'hcc, 8'hcd, 8'hce};
    wire idle_match = RAM_MODE && BUS_ADDR_MATCH && !BUS_BUSY;
    // bus side status
    busy_set_a: assert property (idle_match |=> BUS_BUSY)
        else $error("busy missing after match");
    busy_stop_a: assert property (RAM_MODE && BUS_STOP |=> !BUS_BUSY)
        else $error("busy kept after stop");
    dir_read_a: assert property (idle_match |=> BUS_DIR_READ == $past(BUS_READ))
        else $error("transfer direction wrong");
    // cpu register port
    pad_zero_a: assert property (ptr_rd |=> CPU_RDATA[7:5] == 3'h0)
        else $error("pointer pad bits set");
    rdata_hold_a: assert property (!CPU_RD |=> $stable(CPU_RDATA))
        else $error("read data moved without read");
    base_echo_a: assert property (CPU_WR && CPU_ADDR == 8'hcd ##1
        CPU_RD && CPU_ADDR == 8'hcd |=> CPU_RDATA == {3'h0, $past(CPU_WDATA[4:0], 2)})
        else $error("base pointer readback wrong");
    cur_copy_a: assert property (CPU_WR && CPU_ADDR == 8'hcd ##1
        CPU_RD && CPU_ADDR == 8'hce |=> CPU_RDATA == {3'h0, $past(CPU_WDATA[4:0], 2)})
        else $error("current pointer not loaded with base");
    port_step_a: assert property (CPU_RD && CPU_ADDR == 8'hce ##1
        CPU_RD && CPU_ADDR == 8'hcf ##1 CPU_RD && CPU_ADDR == 8'hce
        |=> CPU_RDATA == (($past(CPU_RDATA, 2) + 8'h01) & 8'h1f))
        else $error("current pointer did not step");
    // main scenarios
    cover property (idle_match && BUS_READ);
    cover property (CPU_RD && CPU_ADDR == 8'hcf);
    cover property (RAM_MODE && BUS_STOP && BUS_BUSY);
endmodule

bind ezram_top ezram_top_chk i_ezram_top_chk (.CLK(CLK), .RSTN(RSTN), .CPU_ADDR(CPU_ADDR),
    .CPU_WR(CPU_WR), .CPU_RD(CPU_RD), .CPU_WDATA(CPU_WDATA), .CPU_RDATA(CPU_RDATA),
    .RAM_MODE(RAM_MODE), .BUS_ADDR_MATCH(BUS_ADDR_MATCH), .BUS_READ(BUS_READ),
    .BUS_STOP(BUS_STOP), .BUS_BUSY(BUS_BUSY), .BUS_DIR_READ(BUS_DIR_READ));

// File: ezram_top_tb.sv
// self checking testbench of the shared ram pointer block
module ezram_top_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import ezram_pkg::*;
    logic clk, rst_n, ram_mode, cpu_wr, cpu_rd, b_start, b_stop, b_match, b_read, b_done;
    byte_t cpu_addr, cpu_wdata, cpu_rdata, b_wdata, b_rdata;
    byte_t none[$];
    int n_mismatch = 0;
    int n_checks = 0;
    // device and bus master
    ezram_top i_ezram_top (.CLK(clk), .RSTN(rst_n), .RAM_MODE(ram_mode), .CPU_ADDR(cpu_addr),
        .CPU_WR(cpu_wr), .CPU_RD(cpu_rd), .CPU_WDATA(cpu_wdata), .CPU_RDATA(cpu_rdata),
        .BUS_START(b_start), .BUS_STOP(b_stop), .BUS_ADDR_MATCH(b_match), .BUS_READ(b_read),
        .BUS_BYTE_DONE(b_done), .BUS_WDATA(b_wdata), .BUS_RDATA(b_rdata), .BUS_BUSY(),
        .BUS_DIR_READ());
    ezram_master_model i_ezram_master_model (.clk(clk), .start(b_start), .stop(b_stop),
        .match(b_match), .rd(b_read), .done(b_done), .wdata(b_wdata), .rdata(b_rdata));
    // 20 MHz clock
    initial begin
        clk = 0;
        forever #25 clk = ~clk;
    end
    task automatic chk(input byte_t seen, input byte_t exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    // one cpu cycle; every strobe is set exactly once per call
    task automatic cop(input logic w, input logic r, input byte_t a, input byte_t d);
        {cpu_wr, cpu_rd, cpu_addr, cpu_wdata} = {w, r, a, d};
        @(posedge clk);
        #1;
    endtask
    task automatic cr(input byte_t a, input byte_t exp);
        cop(0, 1, a, 8'h00);
        chk(cpu_rdata, exp);
    endtask
    task automatic t_reset;
        cr(8'hcc, 8'h00);
        cr(8'hcd, 8'h00);
        cr(8'hce, 8'h00);
        cop(0, 0, 8'h00, 8'h00);
        $display("test reset values done");
    endtask
    task automatic t_host;
        cop(1, 0, 8'hcd, 8'hfe);
        cr(8'hcd, 8'h1e);
        cop(1, 0, 8'hcd, 8'h1e);
        cr(8'hce, 8'h1e);
        cop(1, 0, 8'hcf, 8'haa);
        cop(1, 0, 8'hcf, 8'hbb);
        cop(1, 0, 8'hce, 8'h07);
        cr(8'hce, 8'h00);
        cop(1, 0, 8'hcd, 8'h1e);
        cr(8'hcf, 8'haa);
        cr(8'hce, 8'h1f);
        cr(8'hcf, 8'hbb);
        cr(8'hce, 8'h00);
        cop(0, 0, 8'h00, 8'h00);
        $display("test cpu pointers done");
    endtask
    task automatic t_bus;
        i_ezram_master_model.wr(8'h1f, '{8'h11, 8'h22});
        cr(8'hcc, 8'h01);
        cop(1, 0, 8'hcc, 8'h09);
        cr(8'hcc, 8'h01);
        cop(1, 0, 8'hcd, 8'h1f);
        cr(8'hcf, 8'h11);
        cr(8'hcf, 8'h22);
        cr(8'hc9, 8'h00);
        cop(1, 0, 8'hcd, 8'h03);
        cop(1, 0, 8'hcf, 8'h33);
        cop(1, 0, 8'hcf, 8'h44);
        cop(0, 0, 8'h00, 8'h00);
        i_ezram_master_model.wr(8'h03, none);
        cr(8'hcc, 8'h03);
        cop(0, 0, 8'h00, 8'h00);
        i_ezram_master_model.rd_n(2);
        chk(i_ezram_master_model.got[0], 8'h33);
        chk(i_ezram_master_model.got[1], 8'h44);
        i_ezram_master_model.rd_n(1);
        chk(i_ezram_master_model.got[0], 8'h33);
        $display("test bus transfers done");
    endtask
    task automatic t_shared;
        fork
            i_ezram_master_model.wr(8'h10, '{8'h55, 8'h56});
            begin
                cop(1, 0, 8'hcd, 8'h08);
                repeat (3) cop(1, 0, 8'hcf, 8'h77);
                cop(0, 0, 8'h00, 8'h00);
            end
        join
        cop(1, 0, 8'hcd, 8'h10);
        cr(8'hcf, 8'h55);
        cr(8'hcf, 8'h56);
        cop(1, 0, 8'hcd, 8'h0a);
        cr(8'hcf, 8'h77);
        cop(1, 0, 8'hcd, 8'h0a);
        cop(1, 1, 8'hcf, 8'h88);
        chk(cpu_rdata, 8'h77);
        cr(8'hce, 8'h0b);
        cop(1, 0, 8'hcd, 8'h0a);
        cr(8'hcf, 8'h88);
        cop(0, 0, 8'h00, 8'h00);
        ram_mode = 0;
        i_ezram_master_model.wr(8'h0a, none);
        ram_mode = 1;
        cr(8'hcc, 8'h12);
        cop(0, 0, 8'h00, 8'h00);
        $display("test shared access done");
    endtask
    task automatic stop_test;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // reset, then the scenarios in turn
    initial begin
        {rst_n, ram_mode, cpu_wr, cpu_rd, cpu_addr, cpu_wdata} = {1'b0, 1'b1, 18'h0};
        repeat (10) @(posedge clk);
        #1 rst_n = 1;
        t_reset();
        t_host();
        t_bus();
        t_shared();
        stop_test();
    end
    // watchdog far beyond the hundred or so cycles the scenarios need
    initial begin
        #200000;
        n_mismatch++;
        stop_test();
    end
endmodule
